// ==== core/ppc_phy_port_ctrl.sv ====
//----------------------------------------------------------------------
// Summary of operation
// - Second port's fault count register shows low eight bits of nine-bit distance, 0.4 m each.
// - Negotiation bit set runs negotiation; clear uses speed and duplex bits.
// - Forced speed bit one gives 100 Mb/s, zero gives 10 Mb/s.
// - Forced duplex bit picks full or half when negotiation is off or fails.
// - Five advertise bits each offer a capability when one; default one.
// - LED off bit drives both LED pins of the port high.
// - Transmit disable bit stops the port's transmitter.
// - Writing one to restart bit restarts negotiation on that port.
// - Far-end fault disable bit stops detection and pattern sending.
// - Crossover disable bit turns automatic crossover detection off.
// - With crossover off, force bit picks straight or crossover mode.
// - Loopback bit loops other port's traffic at this port's media layer.
// - Both ports have identical control layouts at separate offsets.
// - Third port slots are reserved and do nothing.
// - Ninth distance bit reads as bit 0 of the special register.
// - Cable test enable starts the test and clears itself on completion.
// - Result reads 00 normal, 01 open, 10 short, 11 failed.
//----------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none

module ppc_phy_port_ctrl
  import ppc_pkg::*;
#(
  parameter int PORTS = 2
)(
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        resetn,
  // Strap pins
  input  wire logic                        firstPortLedAStrap,
  input  wire logic                        firstPortLedBStrap,
  input  wire logic                        hostRxValidStrap,
  input  wire logic                        hostRxBit3Strap,
  input  wire logic                        hostRxBit2Strap,
  input  wire logic                        hostRxBit1Strap,
  // Management register port
  input  wire logic [7:0]                  regAddr,
  input  wire logic                        regWrite,
  input  wire logic [7:0]                  regWriteData,
  input  wire logic                        regRead,
  output logic      [7:0]                  regReadData,
  output logic                             regReadValid,
  // Negotiation results from the transceivers
  input  wire logic [PORTS-1:0]            negFailed,
  input  wire logic [PORTS-1:0]            negSpeed100,
  input  wire logic [PORTS-1:0]            negFullDuplex,
  // LED drive from the transceivers, active low
  input  wire logic [PORTS-1:0][1:0]       ledRawN,
  output logic      [PORTS-1:0][1:0]       ledPinN,
  // Cable diagnostic from the transceivers
  input  wire logic [PORTS-1:0]            cableDone,
  input  wire logic [PORTS-1:0][1:0]       cableResult,
  input  wire logic [PORTS-1:0][FAULT_WIDTH-1:0] cableCount,
  input  wire logic [PORTS-1:0]            cableShort10m,
  output logic      [PORTS-1:0]            cableStart,
  // Link mode to the transceivers
  output logic      [PORTS-1:0]            anEnable,
  output logic      [PORTS-1:0]            anRestart,
  output logic      [PORTS-1:0][4:0]       advertiseCaps,
  output logic      [PORTS-1:0]            linkSpeed100,
  output logic      [PORTS-1:0]            linkFullDuplex,
  output logic      [PORTS-1:0]            forceLinkPass,
  // Transceiver controls
  output logic      [PORTS-1:0]            txDisable,
  output logic      [PORTS-1:0]            farEndFaultOff,
  output logic      [PORTS-1:0]            powerDown,
  output logic      [PORTS-1:0]            mdixAutoEnable,
  output logic      [PORTS-1:0]            mdiStraight,
  // Loopback controls
  output logic      [PORTS-1:0]            loopbackEnable,
  output logic      [PORTS-1:0]            peerLoopTx,
  output logic      [PORTS-1:0]            remoteLoopback
);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  // Loopback pairs one port with the other, so exactly two are served.
  if (PORTS != 2) begin : g_bad_ports
    $error("ppc_phy_port_ctrl serves exactly two transceiver ports");
  end

  // ----------------------------------------------------------------------
  // Per-port address map
  // ----------------------------------------------------------------------
  localparam logic [1:0][7:0] SPECIAL_ADDR = {ADDR_P2_SPECIAL, ADDR_P1_SPECIAL};
  localparam logic [1:0][7:0] FAULT_ADDR   = {ADDR_P2_FAULT, ADDR_P1_FAULT};
  localparam logic [1:0][7:0] CTRL_A_ADDR  = {ADDR_P2_CTRL_A, ADDR_P1_CTRL_A};
  localparam logic [1:0][7:0] CTRL_B_ADDR  = {ADDR_P2_CTRL_B, ADDR_P1_CTRL_B};

  // ----------------------------------------------------------------------
  // Strap routing
  // ----------------------------------------------------------------------
  wire [PORTS-1:0] strapAn     = {hostRxBit3Strap, firstPortLedAStrap};
  wire [PORTS-1:0] strapSpeed  = {hostRxBit2Strap, firstPortLedBStrap};
  wire [PORTS-1:0] strapDuplex = {hostRxBit1Strap, hostRxValidStrap};

  // ----------------------------------------------------------------------
  // Per-port register state
  // ----------------------------------------------------------------------
  logic [PORTS-1:0][7:0]             ctrlA;
  logic [PORTS-1:0][7:0]             ctrlB;
  logic [PORTS-1:0]                  restartPulse;
  logic [PORTS-1:0]                  forceLink;
  logic [PORTS-1:0]                  remoteLoop;
  logic [PORTS-1:0]                  testEnable;
  logic [PORTS-1:0][1:0]             testResult;
  logic [PORTS-1:0][FAULT_WIDTH-1:0] faultCount;
  logic [PORTS-1:0]                  shortNear;
  logic [PORTS-1:0]                  testStartPulse;
  logic [PORTS-1:0][7:0]             specialView;
  logic [PORTS-1:0]                  hitCtrlA;
  logic [PORTS-1:0]                  hitCtrlB;
  logic [PORTS-1:0]                  hitSpecial;
  logic [PORTS-1:0]                  hitFault;

  for (genvar p = 0; p < PORTS; p++) begin : g_port
    // Identical layout per port, only the address differs.
    assign hitCtrlA[p]   = (regAddr == CTRL_A_ADDR[p]);
    assign hitCtrlB[p]   = (regAddr == CTRL_B_ADDR[p]);
    assign hitSpecial[p] = (regAddr == SPECIAL_ADDR[p]);
    assign hitFault[p]   = (regAddr == FAULT_ADDR[p]);

    wire wrCtrlA   = regWrite & hitCtrlA[p];
    wire wrCtrlB   = regWrite & hitCtrlB[p];
    wire wrSpecial = regWrite & hitSpecial[p];
    wire testReq   = wrSpecial & regWriteData[SP_TEST_EN];

    ppc_port_regs u_regs (
      .clock        (clock),
      .resetn       (resetn),
      .strapAn      (strapAn[p]),
      .strapSpeed   (strapSpeed[p]),
      .strapDuplex  (strapDuplex[p]),
      .wrCtrlA      (wrCtrlA),
      .wrCtrlB      (wrCtrlB),
      .wrSpecial    (wrSpecial),
      .wrData       (regWriteData),
      .ctrlA        (ctrlA[p]),
      .ctrlB        (ctrlB[p]),
      .restartPulse (restartPulse[p]),
      .forceLink    (forceLink[p]),
      .remoteLoop   (remoteLoop[p])
    );

    ppc_cable_test u_test (
      .clock      (clock),
      .resetn     (resetn),
      .startReq   (testReq),
      .phyDone    (cableDone[p]),
      .phyResult  (cableResult[p]),
      .phyCount   (cableCount[p]),
      .phyShort   (cableShort10m[p]),
      .phyStart   (testStartPulse[p]),
      .testEnable (testEnable[p]),
      .result     (testResult[p]),
      .faultCount (faultCount[p]),
      .short10m   (shortNear[p])
    );

    assign specialView[p] = {shortNear[p],
                             testResult[p],
                             testEnable[p],
                             forceLink[p],
                             1'b0,
                             remoteLoop[p],
                             faultCount[p][FAULT_WIDTH-1]};

    // --------------------------------------------------------------------
    // Link mode selection
    // --------------------------------------------------------------------
    wire anOn       = ctrlA[p][CA_AN_EN];
    wire useNeg     = anOn & ~negFailed[p];
    // Speed falls back to the negotiated value on failure; only duplex
    // is documented to take the forced bit when negotiation fails.
    wire speedSel   = anOn ? negSpeed100[p] : ctrlA[p][CA_SPEED];
    wire duplexSel  = useNeg ? negFullDuplex[p] : ctrlA[p][CA_DUPLEX];
    wire mdixOff    = ctrlB[p][CB_MDIX_DIS];
    wire straightOn = mdixOff & ctrlB[p][CB_FORCE_MDI];
    wire ledOff     = ctrlB[p][CB_LED_OFF];

    // --------------------------------------------------------------------
    // Output registers
    // --------------------------------------------------------------------
    always_ff @(posedge clock) begin
      if (!resetn) begin
        anEnable[p]       <= 1'b0;
        anRestart[p]      <= 1'b0;
        advertiseCaps[p]  <= '0;
        linkSpeed100[p]   <= 1'b0;
        linkFullDuplex[p] <= 1'b0;
        forceLinkPass[p]  <= 1'b0;
        cableStart[p]     <= 1'b0;
      end else begin
        anEnable[p]       <= anOn;
        anRestart[p]      <= restartPulse[p];
        advertiseCaps[p]  <= ctrlA[p][CA_ADV_MSB:0];
        linkSpeed100[p]   <= speedSel;
        linkFullDuplex[p] <= duplexSel;
        forceLinkPass[p]  <= forceLink[p];
        cableStart[p]     <= testStartPulse[p];
      end
    end

    always_ff @(posedge clock) begin
      if (!resetn) begin
        ledPinN[p]        <= 2'b11;
        txDisable[p]      <= 1'b0;
        farEndFaultOff[p] <= 1'b0;
        powerDown[p]      <= 1'b0;
        mdixAutoEnable[p] <= 1'b1;
        mdiStraight[p]    <= 1'b0;
      end else begin
        ledPinN[p]        <= ledOff ? 2'b11 : ledRawN[p];
        txDisable[p]      <= ctrlB[p][CB_TX_DIS];
        farEndFaultOff[p] <= ctrlB[p][CB_FEF_DIS];
        powerDown[p]      <= ctrlB[p][CB_PWR_DN];
        mdixAutoEnable[p] <= ~mdixOff;
        mdiStraight[p]    <= straightOn;
      end
    end

    // A port's loopback is carried out on the other port's wire pair:
    // traffic enters there, turns at this port's media layer and leaves
    // there again.
    always_ff @(posedge clock) begin
      if (!resetn) begin
        loopbackEnable[p] <= 1'b0;
        peerLoopTx[p]     <= 1'b0;
        remoteLoopback[p] <= 1'b0;
      end else begin
        loopbackEnable[p] <= ctrlB[p][CB_LOOP];
        peerLoopTx[p]     <= ctrlB[PORTS-1-p][CB_LOOP];
        remoteLoopback[p] <= remoteLoop[p];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // The first port's distance register is not supported and reads zero;
  // its ninth bit is still visible in the special register.
  wire       hitReserved = (regAddr == ADDR_P3_RSVD_A) ||
                           (regAddr == ADDR_P3_RSVD_B) ||
                           (regAddr == ADDR_P3_RSVD_C);
  wire [7:0] faultView   = faultCount[1][7:0];

  logic [7:0] readMux;

  always_comb begin
    readMux = 8'h00;
    if (hitReserved) begin
      readMux = 8'h00;
    end else if (hitCtrlA[0]) begin
      readMux = ctrlA[0];
    end else if (hitCtrlA[1]) begin
      readMux = ctrlA[1];
    end else if (hitCtrlB[0]) begin
      readMux = ctrlB[0];
    end else if (hitCtrlB[1]) begin
      readMux = ctrlB[1];
    end else if (hitSpecial[0]) begin
      readMux = specialView[0];
    end else if (hitSpecial[1]) begin
      readMux = specialView[1];
    end else if (hitFault[1]) begin
      readMux = faultView;
    end
  end

  // Reads have no side effects, so a held read strobe just repeats.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      regReadData  <= 8'h00;
      regReadValid <= 1'b0;
    end else begin
      regReadValid <= regRead;
      if (regRead) begin
        regReadData <= readMux;
      end
    end
  end

endmodule : ppc_phy_port_ctrl

`default_nettype wire

// ==== core/ppc_pkg.sv ====
package ppc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_P1_SPECIAL = 8'h1A;
  localparam logic [7:0] ADDR_P1_FAULT   = 8'h1B;
  localparam logic [7:0] ADDR_P1_CTRL_A  = 8'h1C;
  localparam logic [7:0] ADDR_P1_CTRL_B  = 8'h1D;
  localparam logic [7:0] ADDR_P2_SPECIAL = 8'h2A;
  localparam logic [7:0] ADDR_P2_FAULT   = 8'h2B;
  localparam logic [7:0] ADDR_P2_CTRL_A  = 8'h2C;
  localparam logic [7:0] ADDR_P2_CTRL_B  = 8'h2D;
  localparam logic [7:0] ADDR_P3_RSVD_A  = 8'h3B;
  localparam logic [7:0] ADDR_P3_RSVD_B  = 8'h3C;
  localparam logic [7:0] ADDR_P3_RSVD_C  = 8'h3D;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CA_AN_EN      = 7;
  localparam int CA_SPEED      = 6;
  localparam int CA_DUPLEX     = 5;
  localparam int CA_ADV_MSB    = 4;
  localparam int CB_LED_OFF    = 7;
  localparam int CB_TX_DIS     = 6;
  localparam int CB_RESTART    = 5;
  localparam int CB_FEF_DIS    = 4;
  localparam int CB_PWR_DN     = 3;
  localparam int CB_MDIX_DIS   = 2;
  localparam int CB_FORCE_MDI  = 1;
  localparam int CB_LOOP       = 0;
  localparam int SP_SHORT      = 7;
  localparam int SP_RESULT_LSB = 5;
  localparam int SP_TEST_EN    = 4;
  localparam int SP_FORCE_LINK = 3;
  localparam int SP_REMOTE_LB  = 1;
  localparam int SP_COUNT_MSB  = 0;

  // ----------------------------------------------------------------------
  // Reset values, widths and types
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_A_RESET  = 8'hFF;
  localparam logic [7:0] CTRL_B_RESET  = 8'h00;
  localparam int         FAULT_WIDTH   = 9;
  localparam int         FAULT_STEP_CM = 40;

  typedef enum logic [1:0] {
    RESULT_NORMAL = 2'b00,
    RESULT_OPEN   = 2'b01,
    RESULT_SHORT  = 2'b10,
    RESULT_FAILED = 2'b11
  } ppc_result_t;

  typedef enum logic [1:0] {
    TEST_IDLE = 2'b01,
    TEST_RUN  = 2'b10
  } ppc_test_state_t;

endpackage : ppc_pkg

// ==== core/ppc_port_regs.sv ====
`timescale 1ns/10ps
`default_nettype none

module ppc_port_regs
  import ppc_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // Strap levels for this port
  input  wire logic       strapAn,
  input  wire logic       strapSpeed,
  input  wire logic       strapDuplex,
  // Write strobes and data
  input  wire logic       wrCtrlA,
  input  wire logic       wrCtrlB,
  input  wire logic       wrSpecial,
  input  wire logic [7:0] wrData,
  // Register contents
  output logic      [7:0] ctrlA,
  output logic      [7:0] ctrlB,
  output logic            restartPulse,
  output logic            forceLink,
  output logic            remoteLoop
);

  // While reset is held the strap pins are copied every cycle, so the
  // level present at release is the one kept.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctrlA <= {strapAn, strapSpeed, strapDuplex, CTRL_A_RESET[CA_ADV_MSB:0]};
    end else if (wrCtrlA) begin
      ctrlA <= wrData;
    end
  end

  // The restart bit is not stored: it is a command and always reads zero.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctrlB        <= CTRL_B_RESET;
      restartPulse <= 1'b0;
    end else begin
      restartPulse <= wrCtrlB & wrData[CB_RESTART];
      if (wrCtrlB) begin
        ctrlB              <= wrData;
        ctrlB[CB_RESTART] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      forceLink  <= 1'b0;
      remoteLoop <= 1'b0;
    end else if (wrSpecial) begin
      forceLink  <= wrData[SP_FORCE_LINK];
      remoteLoop <= wrData[SP_REMOTE_LB];
    end
  end

endmodule : ppc_port_regs

`default_nettype wire

// ==== core/ppc_cable_test.sv ====
`timescale 1ns/10ps
`default_nettype none

module ppc_cable_test
  import ppc_pkg::*;
(
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   resetn,
  // Software request
  input  wire logic                   startReq,
  // Transceiver diagnostic
  input  wire logic                   phyDone,
  input  wire logic [1:0]             phyResult,
  input  wire logic [FAULT_WIDTH-1:0] phyCount,
  input  wire logic                   phyShort,
  output logic                        phyStart,
  // Register view
  output logic                        testEnable,
  output logic      [1:0]             result,
  output logic      [FAULT_WIDTH-1:0] faultCount,
  output logic                        short10m
);

  ppc_test_state_t state_q;
  ppc_test_state_t state_d;

  wire finishNow = (state_q == TEST_RUN) && phyDone && !startReq;

  always_comb begin
    case (state_q)
      TEST_IDLE: state_d = startReq ? TEST_RUN : TEST_IDLE;
      TEST_RUN:  state_d = finishNow ? TEST_IDLE : TEST_RUN;
      default:   state_d = TEST_IDLE;
    endcase
  end

  // A new request in the same cycle as completion restarts the test,
  // so the enable bit stays set rather than dropping for one read.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q    <= TEST_IDLE;
      phyStart   <= 1'b0;
      result     <= RESULT_NORMAL;
      faultCount <= '0;
      short10m   <= 1'b0;
    end else begin
      state_q  <= state_d;
      phyStart <= startReq;
      if (finishNow) begin
        result     <= phyResult;
        faultCount <= phyCount;
        short10m   <= phyShort;
      end
    end
  end

  assign testEnable = (state_q == TEST_RUN);

endmodule : ppc_cable_test

`default_nettype wire

// ==== verif/ppc_phy_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Far-side cable diagnostic responder
// ----------------------------------------
module ppc_phy_model
  import ppc_pkg::*;
#(
  parameter int DLY = 20
)(
  // Clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // Test request and answer
  input  wire logic [1:0] cableStart,
  input  wire logic [1:0] resCode,
  input  wire logic [FAULT_WIDTH-1:0] resCount,
  input  wire logic resShort,
  output logic [1:0] cableDone,
  output logic [1:0][1:0] cableResult,
  output logic [1:0][FAULT_WIDTH-1:0] cableCount,
  output logic [1:0] cableShort10m
);
  int cnt [2];
  always_ff @(posedge clock) begin
    for (int p = 0; p < 2; p++) begin
      cableDone[p] <= 1'b0;
      if (!resetn) cnt[p] <= 0;
      else if (cableStart[p]) cnt[p] <= DLY;
      else if (cnt[p] == 1) begin
        cnt[p] <= 0;
        cableDone[p] <= 1'b1;
      end else if (cnt[p] != 0) cnt[p] <= cnt[p] - 1;
    end
  end
  // Off the done cycle the lines carry the inverse, so late sampling shows up.
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      cableResult[p] = cableDone[p] ? resCode : ~resCode;
      cableCount[p] = cableDone[p] ? resCount : ~resCount;
      cableShort10m[p] = cableDone[p] ? resShort : ~resShort;
    end
  end
endmodule : ppc_phy_model
`default_nettype wire

// ==== verif/ppc_phy_port_ctrl_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module ppc_phy_port_ctrl_monitor
  import ppc_pkg::*;
#(
  parameter int PORTS = 2
)(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWriteData,
  input wire logic regRead,
  input wire logic [7:0] regReadData,
  input wire logic regReadValid,
  // Port controls
  input wire logic [PORTS-1:0][1:0] ledPinN,
  input wire logic [PORTS-1:0] cableStart,
  input wire logic [PORTS-1:0] anEnable,
  input wire logic [PORTS-1:0] anRestart,
  input wire logic [PORTS-1:0][4:0] advertiseCaps,
  input wire logic [PORTS-1:0] linkSpeed100,
  input wire logic [PORTS-1:0] linkFullDuplex,
  input wire logic [PORTS-1:0] txDisable,
  input wire logic [PORTS-1:0] farEndFaultOff,
  input wire logic [PORTS-1:0] powerDown,
  input wire logic [PORTS-1:0] mdixAutoEnable,
  input wire logic [PORTS-1:0] mdiStraight,
  input wire logic [PORTS-1:0] loopbackEnable,
  input wire logic [PORTS-1:0] peerLoopTx
);
  logic [7:0] d1_q;
  logic [7:0] d2_q;
  always_ff @(posedge clock) begin
    d1_q <= regWriteData;
    d2_q <= d1_q;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_wr(logic [7:0] a);
    regWrite && regAddr == a;
  endsequence
  a_rsvd_reads_zero: assert property (regRead && regAddr inside {[8'h3B:8'h3D]}
    |=> regReadValid && regReadData == 8'h00) else $error("reserved read not zero");
  a_led_forced_off: assert property (s_wr(ADDR_P1_CTRL_B) ##0 regWriteData[7]
    |-> ##2 ledPinN[0] == 2'b11) else $error("led pins not high");
  a_forced_link_mode: assert property (s_wr(ADDR_P1_CTRL_A) ##0 !regWriteData[7]
    |-> ##2 !anEnable[0] && linkSpeed100[0] == d2_q[6] && linkFullDuplex[0] == d2_q[5])
    else $error("forced mode wrong");
  a_adv_caps: assert property (s_wr(ADDR_P2_CTRL_A)
    |-> ##2 advertiseCaps[1] == d2_q[4:0]) else $error("advertise wrong");
  a_tx_fef_pwr: assert property (s_wr(ADDR_P2_CTRL_B)
    |-> ##2 {txDisable[1], farEndFaultOff[1], powerDown[1]} == {d2_q[6], d2_q[4], d2_q[3]})
    else $error("port controls wrong");
  a_crossover_mode: assert property (s_wr(ADDR_P1_CTRL_B)
    |-> ##2 mdixAutoEnable[0] == !d2_q[2] && mdiStraight[0] == (d2_q[2] && d2_q[1]))
    else $error("crossover wrong");
  a_loop_cross: assert property (s_wr(ADDR_P2_CTRL_B)
    |-> ##2 loopbackEnable[1] == d2_q[0] && peerLoopTx[0] == d2_q[0]) else $error("loopback wrong");
  a_restart_cmd: assert property (s_wr(ADDR_P2_CTRL_B) ##0 regWriteData[5]
    |-> ##2 anRestart[1]) else $error("restart missing");
  a_test_start: assert property (s_wr(ADDR_P2_SPECIAL) ##0 regWriteData[4]
    |-> ##2 cableStart[1]) else $error("cable start missing");
endmodule : ppc_phy_port_ctrl_monitor
bind ppc_phy_port_ctrl ppc_phy_port_ctrl_monitor #(.PORTS(PORTS)) u_mon (.clock, .resetn, .regAddr,
  .regWrite, .regWriteData, .regRead, .regReadData, .regReadValid, .ledPinN, .cableStart, .anEnable,
  .anRestart, .advertiseCaps, .linkSpeed100, .linkFullDuplex, .txDisable, .farEndFaultOff,
  .powerDown, .mdixAutoEnable, .mdiStraight, .loopbackEnable, .peerLoopTx);
`default_nettype wire

// ==== verif/ppc_phy_port_ctrl_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module ppc_phy_port_ctrl_tb
  import ppc_pkg::*;
  ;
  logic clock, resetn, regWrite, regRead, regReadValid, resShort;
  logic [5:0] straps;
  logic [7:0] regAddr, regWriteData, regReadData, d;
  logic [1:0] negFailed, negSpeed100, negFullDuplex, cableDone, cableShort10m, cableStart, resCode;
  logic [1:0] anEnable, anRestart, linkSpeed100, linkFullDuplex, forceLinkPass, txDisable;
  logic [1:0] farEndFaultOff, powerDown, mdixAutoEnable, mdiStraight, loopbackEnable;
  logic [1:0] peerLoopTx, remoteLoopback;
  logic [1:0][1:0] ledRawN, ledPinN, cableResult;
  logic [1:0][FAULT_WIDTH-1:0] cableCount;
  logic [1:0][4:0] advertiseCaps;
  logic [8:0] resCount;
  int n_mismatch, n_compared;
  ppc_phy_port_ctrl #(.PORTS(2)) dut (.clock, .resetn, .firstPortLedAStrap(straps[5]),
    .firstPortLedBStrap(straps[4]), .hostRxValidStrap(straps[3]), .hostRxBit3Strap(straps[2]),
    .hostRxBit2Strap(straps[1]), .hostRxBit1Strap(straps[0]), .regAddr, .regWrite, .regWriteData,
    .regRead, .regReadData, .regReadValid, .negFailed, .negSpeed100, .negFullDuplex, .ledRawN,
    .ledPinN, .cableDone, .cableResult, .cableCount, .cableShort10m, .cableStart, .anEnable,
    .anRestart, .advertiseCaps, .linkSpeed100, .linkFullDuplex, .forceLinkPass, .txDisable,
    .farEndFaultOff, .powerDown, .mdixAutoEnable, .mdiStraight, .loopbackEnable, .peerLoopTx,
    .remoteLoopback);
  ppc_phy_model #(.DLY(20)) u_far (.clock, .resetn, .cableStart, .resCode, .resCount, .resShort,
    .cableDone, .cableResult, .cableCount, .cableShort10m);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ----------------------------------------
  // Register access and scenarios
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock);
    regWrite = 1'b1;
    regAddr = a;
    regWriteData = v;
    @(negedge clock);
    regWrite = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clock);
    regRead = 1'b1;
    regAddr = a;
    @(negedge clock);
    regRead = 1'b0;
    `CHK("valid", 1'b1, regReadValid)
    v = regReadData;
  endtask : rd
  task automatic t_rsvd();
    logic [7:0] a [4] = '{8'h3B, 8'h3C, 8'h3D, 8'h2B};
    logic [7:0] e [4] = '{8'h5F, 8'h00, 8'h9F, 8'h00};
    for (int i = 0; i < 4; i++) wr(a[i], 8'hFF);
    for (int i = 0; i < 3; i++) begin
      rd(a[i], d);
      `CHK("rsvd", 8'h00, d)
    end
    for (int i = 0; i < 4; i++) begin
      rd(8'h1C + 8'h10 * i[1] + i[0], d);
      `CHK("ctrl reset", e[i], d)
    end
    `CHK("pdn", 2'b00, powerDown)
    $display("test reserved done");
  endtask : t_rsvd
  task automatic t_mode();
    logic [7:0] v [5] = '{8'h60, 8'h4A, 8'h35, 8'h00, 8'hBF};
    for (int f = 0; f < 2; f++) begin
      negFailed = {f[0], f[0]};
      for (int p = 0; p < 2; p++) begin
        for (int i = 0; i < 5; i++) begin
          wr(p ? ADDR_P2_CTRL_A : ADDR_P1_CTRL_A, v[i]);
          @(negedge clock);
          `CHK("an", v[i][7], anEnable[p])
          `CHK("spd", v[i][7] ? 1'b1 : v[i][6], linkSpeed100[p])
          `CHK("dup", (v[i][7] && !f[0]) ? 1'b0 : v[i][5], linkFullDuplex[p])
          `CHK("adv", v[i][4:0], advertiseCaps[p])
          rd(p ? ADDR_P2_CTRL_A : ADDR_P1_CTRL_A, d);
          `CHK("ctrlA rb", v[i], d)
        end
      end
    end
    $display("test link mode done");
  endtask : t_mode
  task automatic t_ctrlb();
    logic [7:0] v [10] = '{8'h80, 8'h40, 8'h10, 8'h08, 8'h04, 8'h06, 8'h02, 8'h01, 8'hA0, 8'h00};
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 10; i++) begin
        wr(p ? ADDR_P2_CTRL_B : ADDR_P1_CTRL_B, v[i]);
        @(negedge clock);
        `CHK("restart", v[i][5], anRestart[p])
        `CHK("led", v[i][7] ? 2'b11 : ledRawN[p], ledPinN[p])
        `CHK("tx", v[i][6], txDisable[p])
        `CHK("fef", v[i][4], farEndFaultOff[p])
        `CHK("pdn", v[i][3], powerDown[p])
        `CHK("mdix", !v[i][2], mdixAutoEnable[p])
        `CHK("mdi", v[i][2] & v[i][1], mdiStraight[p])
        `CHK("loop", {v[i][0], v[i][0]}, {loopbackEnable[p], peerLoopTx[!p]})
        rd(p ? ADDR_P2_CTRL_B : ADDR_P1_CTRL_B, d);
        `CHK("restart", 1'b0, anRestart[p])
        `CHK("ctrlB rb", v[i] & 8'hDF, d)
      end
    end
    $display("test port controls done");
  endtask : t_ctrlb
  task automatic t_cable();
    for (int c = 0; c < 4; c++) begin
      resCode = c[1:0];
      resCount = 9'h1A5 ^ {c[1:0], 7'h00};
      resShort = c[1];
      wr(ADDR_P2_SPECIAL, 8'h10);
      rd(ADDR_P2_SPECIAL, d);
      `CHK("testEn", 1'b1, d[4])
      for (int i = 0; i < 60 && cableDone[1] !== 1'b1; i++) @(negedge clock);
      `CHK("done", 1'b1, cableDone[1])
      rd(ADDR_P2_SPECIAL, d);
      `CHK("special", {resShort, resCode, 4'h0, resCount[8]}, d)
      rd(ADDR_P2_FAULT, d);
      `CHK("count", resCount[7:0], d)
    end
    wr(ADDR_P1_SPECIAL, 8'h0A);
    rd(ADDR_P1_SPECIAL, d);
    `CHK("p1 special", 8'h0A, d)
    `CHK("flags", 4'h5, {forceLinkPass, remoteLoopback})
    $display("test cable done");
  endtask : t_cable
  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    close_out();
  end
  initial begin
    resetn = 1'b0;
    straps = 6'h14;
    {regWrite, regRead, regAddr, regWriteData} = 18'h0_0000;
    {negFailed, negSpeed100, negFullDuplex} = 6'h0C;
    ledRawN = 4'h9;
    {resCode, resCount, resShort} = 12'h000;
    repeat (5) @(negedge clock);
    `CHK("led rst", 4'hF, ledPinN)
    `CHK("mdix rst", 2'b11, mdixAutoEnable)
    resetn = 1'b1;
    t_rsvd();
    t_mode();
    t_ctrlb();
    t_cable();
    close_out();
  end
endmodule : ppc_phy_port_ctrl_tb
`default_nettype wire
